// *** capture_pkg.sv ***
`default_nettype none
package capture_pkg;

    // Byte addresses of the registers on the AHB-Lite slave.
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_CAP_LO   = 8'h04;
    localparam logic [7:0] ADDR_CAP_HI   = 8'h08;
    localparam logic [7:0] ADDR_FLAG     = 8'h0c;
    localparam logic [7:0] ADDR_ENABLE   = 8'h10;
    localparam logic [7:0] ADDR_ALTPIN   = 8'h14;
    localparam logic [7:0] ADDR_TMR_CTRL = 8'h18;
    localparam logic [7:0] ADDR_TMR_LO   = 8'h1c;
    localparam logic [7:0] ADDR_TMR_HI   = 8'h20;
    localparam logic [7:0] ADDR_PIN_CTRL = 8'h24;

    // AHB-Lite encodings.
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD    = 3'h2;

    // Mode field codes; MODE_OFF disables capture, the others select a capture event.
    localparam logic [3:0] MODE_OFF    = 4'h0;
    localparam logic [3:0] MODE_FALL   = 4'h4;
    localparam logic [3:0] MODE_RISE   = 4'h5;
    localparam logic [3:0] MODE_RISE4  = 4'h6;
    localparam logic [3:0] MODE_RISE16 = 4'h7;

    // Field positions.
    localparam int MODE_LSB     = 0;
    localparam int MODE_MSB     = 3;
    localparam int FLAG_BIT     = 2;
    localparam int ENABLE_BIT   = 2;
    localparam int SEL_BIT      = 0;
    localparam int TMR_ON_BIT   = 0;
    localparam int TMR_SRC_BIT  = 1;
    localparam int PIN_DIR_BIT  = 0;
    localparam int PIN_LAT_BIT  = 1;

    // Prescaler terminal counts.
    localparam logic [3:0] PS_ZERO   = 4'h0;
    localparam logic [3:0] PS4_LAST  = 4'h3;
    localparam logic [3:0] PS16_LAST = 4'hf;
    localparam logic [3:0] PS4_MASK  = 4'h3;

    // Instruction clock is the core clock divided by four.
    localparam logic [1:0] DIV_ZERO = 2'h0;
    localparam logic [1:0] DIV_LAST = 2'h3;

    // Reset values.
    localparam logic [7:0]  CTRL_RST     = 8'h00;
    localparam logic [15:0] VALUE_RST    = 16'h0000;
    localparam logic [1:0]  TMR_CTRL_RST = 2'h0;
    localparam logic [1:0]  PIN_CTRL_RST = 2'h1;

    // True for the four mode codes that capture.
    function automatic logic is_capture_mode(input logic [3:0] mode);
        is_capture_mode = (mode == MODE_FALL) || (mode == MODE_RISE) ||
                          (mode == MODE_RISE4) || (mode == MODE_RISE16);
    endfunction

endpackage
`default_nettype wire

// *** capture_edge_detect.sv ***
`timescale 1ns/1ps
`default_nettype none
module capture_edge_detect
(
    input  wire logic core_clk,
    input  wire logic nrst,
    input  wire logic level_in,
    output var  logic rise_pulse,
    output var  logic fall_pulse
);

    logic sync1_ff;
    logic sync2_ff;
    logic prev_ff;
    logic nxt_sync1;
    logic nxt_sync2;
    logic nxt_prev;

    // Two-stage synchroniser; edges are taken only from the second stage.
    always_comb
    begin
        nxt_sync1 = level_in;
        nxt_sync2 = sync1_ff;
        nxt_prev  = sync2_ff;
    end

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            prev_ff  <= 1'b0;
        end
        else
        begin
            sync1_ff <= nxt_sync1;
            sync2_ff <= nxt_sync2;
            prev_ff  <= nxt_prev;
        end
    end

    assign rise_pulse = sync2_ff & ~prev_ff;
    assign fall_pulse = ~sync2_ff & prev_ff;

endmodule
`default_nettype wire

// *** timer_capture_unit.sv ***
// How it works
// - Each capture event copies the 16-bit timer into the high and low capture bytes.
// - Mode field picks falling, rising, every 4th or every 16th rising edge.
// - Every stored capture sets the capture interrupt flag.
// - A new capture overwrites the held value even if unread.
// - Prescaler stays zero while off or in any non-capture mode.
// - Any reset clears the prescaler counter.
// - Switching between capture prescale settings keeps the counter; spurious captures possible.
// - Changing capture mode may raise a false flag; not suppressed.
// - On the instruction clock the timer halts in sleep and resumes afterwards.
// - On the external clock capture keeps working in sleep.
// - With the pin driven as output, latch writes giving edges capture.
// - A pin select bit moves the capture input to the alternate pin.
//
// The placing of the registers and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module timer_capture_unit
    import capture_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic        hreadyout,
    output var  logic        hresp,
    output var  logic [31:0] hrdata,
    input  wire logic        sleep_mode,
    input  wire logic        ext_timer_clk,
    input  wire logic        pin_main_in,
    output var  logic        pin_main_out,
    output var  logic        pin_main_oe,
    input  wire logic        pin_alt_in,
    output var  logic        pin_alt_out,
    output var  logic        pin_alt_oe
);

    logic [7:0]  ctrl_ff;
    logic [15:0] capture_ff;
    logic        flag_ff;
    logic        enable_ff;
    logic        sel_ff;
    logic [1:0]  tmr_ctrl_ff;
    logic [15:0] timer_ff;
    logic [1:0]  div_ff;
    logic [3:0]  ps_ff;
    logic [1:0]  pin_ctrl_ff;
    logic        wr_pend_ff;
    logic [7:0]  wr_addr_ff;
    logic [31:0] hrdata_ff;
    logic        hreadyout_ff;
    logic        pin_main_out_ff;
    logic        pin_main_oe_ff;
    logic        pin_alt_out_ff;
    logic        pin_alt_oe_ff;

    logic [7:0]  nxt_ctrl;
    logic [15:0] nxt_capture;
    logic        nxt_flag;
    logic        nxt_enable;
    logic        nxt_sel;
    logic [1:0]  nxt_tmr_ctrl;
    logic [15:0] nxt_timer;
    logic [1:0]  nxt_div;
    logic [3:0]  nxt_ps;
    logic [1:0]  nxt_pin_ctrl;
    logic        nxt_wr_pend;
    logic [7:0]  nxt_wr_addr;
    logic [31:0] nxt_hrdata;
    logic        nxt_pin_main_out;
    logic        nxt_pin_main_oe;
    logic        nxt_pin_alt_out;
    logic        nxt_pin_alt_oe;

    logic        addr_phase;
    logic [7:0]  addr_low;
    logic [7:0]  wbyte;
    logic        wr_now;
    logic [3:0]  mode;
    logic        capture_on;
    logic        pin_driven;
    logic        pin_level;
    logic        pin_rise;
    logic        pin_fall;
    logic        ext_rise;
    logic        instr_tick;
    logic        timer_tick;
    logic        edge_hit;
    logic        capture_event;

    assign mode       = ctrl_ff[MODE_MSB:MODE_LSB];
    assign capture_on = is_capture_mode(mode);

    // Route the selected pin location; a driven pin reads its own latch.
    // alternate pin select
    always_comb
    begin
        pin_driven = ~pin_ctrl_ff[PIN_DIR_BIT];
        if (pin_driven)
        begin
            pin_level = pin_ctrl_ff[PIN_LAT_BIT];
        end
        else if (sel_ff)
        begin
            pin_level = pin_alt_in;
        end
        else
        begin
            pin_level = pin_main_in;
        end
    end

    capture_edge_detect u_pin_edge
    (
        .core_clk   (core_clk),
        .nrst       (nrst),
        .level_in   (pin_level),
        .rise_pulse (pin_rise),
        .fall_pulse (pin_fall)
    );

    // The external timer clock is sampled like any other synchronous input.
    capture_edge_detect u_ext_edge
    (
        .core_clk   (core_clk),
        .nrst       (nrst),
        .level_in   (ext_timer_clk),
        .rise_pulse (ext_rise),
        .fall_pulse ()
    );

    // Timer clock selection and the divide-by-four instruction tick.
    // timer clock source
    always_comb
    begin
        instr_tick = (div_ff == DIV_LAST) && !sleep_mode;
        if (!tmr_ctrl_ff[TMR_ON_BIT])
        begin
            timer_tick = 1'b0;
        end
        else if (tmr_ctrl_ff[TMR_SRC_BIT])
        begin
            timer_tick = ext_rise;
        end
        else
        begin
            timer_tick = instr_tick;
        end
    end

    // Event qualification through the edge prescaler.
    // event select
    always_comb
    begin
        edge_hit      = 1'b0;
        capture_event = 1'b0;
        unique case (mode)
            MODE_FALL:
            begin
                edge_hit      = pin_fall;
                capture_event = pin_fall;
            end
            MODE_RISE:
            begin
                edge_hit      = pin_rise;
                capture_event = pin_rise;
            end
            MODE_RISE4:
            begin
                edge_hit      = pin_rise;
                capture_event = pin_rise && ((ps_ff & PS4_MASK) == PS4_LAST);
            end
            MODE_RISE16:
            begin
                edge_hit      = pin_rise;
                capture_event = pin_rise && (ps_ff == PS16_LAST);
            end
            default:
            begin
                edge_hit      = 1'b0;
                capture_event = 1'b0;
            end
        endcase
    end

    // AHB-Lite address phase decode; zero wait states.
    assign addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ) && (hsize == HSIZE_WORD);
    assign addr_low   = haddr[7:0];
    assign wr_now     = wr_pend_ff;
    assign wbyte      = hwdata[7:0];

    always_comb
    begin
        nxt_wr_pend = addr_phase && hwrite;
        nxt_wr_addr = addr_phase ? addr_low : wr_addr_ff;
        nxt_hrdata  = 32'h0000_0000;
        if (addr_phase && !hwrite)
        begin
            unique case (addr_low)
                ADDR_CTRL:     nxt_hrdata[7:0] = ctrl_ff;
                ADDR_CAP_LO:   nxt_hrdata[7:0] = capture_ff[7:0];
                ADDR_CAP_HI:   nxt_hrdata[7:0] = capture_ff[15:8];
                ADDR_FLAG:     nxt_hrdata[FLAG_BIT] = flag_ff;
                ADDR_ENABLE:   nxt_hrdata[ENABLE_BIT] = enable_ff;
                ADDR_ALTPIN:   nxt_hrdata[SEL_BIT] = sel_ff;
                ADDR_TMR_CTRL: nxt_hrdata[1:0] = tmr_ctrl_ff;
                ADDR_TMR_LO:   nxt_hrdata[7:0] = timer_ff[7:0];
                ADDR_TMR_HI:   nxt_hrdata[7:0] = timer_ff[15:8];
                ADDR_PIN_CTRL: nxt_hrdata[1:0] = pin_ctrl_ff;
                default:       nxt_hrdata = 32'h0000_0000;
            endcase
        end
    end

    // Register writes land in the data phase; capture events win over writes, but a timer write wins over a timer tick.
    always_comb
    begin
        nxt_ctrl     = ctrl_ff;
        nxt_capture  = capture_ff;
        nxt_flag     = flag_ff;
        nxt_enable   = enable_ff;
        nxt_sel      = sel_ff;
        nxt_tmr_ctrl = tmr_ctrl_ff;
        nxt_pin_ctrl = pin_ctrl_ff;
        nxt_timer    = timer_ff;
        if (wr_now)
        begin
            unique case (wr_addr_ff)
                ADDR_CTRL:     nxt_ctrl = wbyte;
                ADDR_CAP_LO:   nxt_capture[7:0] = wbyte;
                ADDR_CAP_HI:   nxt_capture[15:8] = wbyte;
                ADDR_FLAG:     nxt_flag = wbyte[FLAG_BIT];
                ADDR_ENABLE:   nxt_enable = wbyte[ENABLE_BIT];
                ADDR_ALTPIN:   nxt_sel = wbyte[SEL_BIT];
                ADDR_TMR_CTRL: nxt_tmr_ctrl = wbyte[1:0];
                ADDR_TMR_LO:   nxt_timer[7:0] = wbyte;
                ADDR_TMR_HI:   nxt_timer[15:8] = wbyte;
                ADDR_PIN_CTRL: nxt_pin_ctrl = wbyte[1:0];
                default:       nxt_ctrl = ctrl_ff;
            endcase
        end
        if (timer_tick && !(wr_now && ((wr_addr_ff == ADDR_TMR_LO) ||
                                        (wr_addr_ff == ADDR_TMR_HI))))
        begin
            nxt_timer = timer_ff + 16'h0001;
        end
        if (capture_event)
        begin
            nxt_capture = timer_ff;
        end
        if (capture_event)
        begin
            nxt_flag = 1'b1;
        end
    end

    // Prescaler counts qualifying edges and is zero outside capture modes.
    // prescaler held clear
    always_comb
    begin
        if (!capture_on)
        begin
            nxt_ps = PS_ZERO;
        end
        else if (edge_hit)
        begin
            nxt_ps = ps_ff + 4'h1;
        end
        else
        begin
            nxt_ps = ps_ff;
        end
        nxt_div = (div_ff == DIV_LAST) ? DIV_ZERO : div_ff + 2'h1;
        if (sleep_mode)
        begin
            nxt_div = div_ff;
        end
    end

    // Pin drivers follow the direction and latch bits at the chosen location.
    always_comb
    begin
        nxt_pin_main_out = nxt_pin_ctrl[PIN_LAT_BIT] && !nxt_sel;
        nxt_pin_main_oe  = !nxt_pin_ctrl[PIN_DIR_BIT] && !nxt_sel;
        nxt_pin_alt_out  = nxt_pin_ctrl[PIN_LAT_BIT] && nxt_sel;
        nxt_pin_alt_oe   = !nxt_pin_ctrl[PIN_DIR_BIT] && nxt_sel;
    end

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            ctrl_ff         <= CTRL_RST;
            capture_ff      <= VALUE_RST;
            flag_ff         <= 1'b0;
            enable_ff       <= 1'b0;
            sel_ff          <= 1'b0;
            tmr_ctrl_ff     <= TMR_CTRL_RST;
            timer_ff        <= VALUE_RST;
            div_ff          <= DIV_ZERO;
            ps_ff           <= PS_ZERO;
            pin_ctrl_ff     <= PIN_CTRL_RST;
            wr_pend_ff      <= 1'b0;
            wr_addr_ff      <= ADDR_CTRL;
            hrdata_ff       <= 32'h0000_0000;
            hreadyout_ff    <= 1'b1;
            pin_main_out_ff <= 1'b0;
            pin_main_oe_ff  <= 1'b0;
            pin_alt_out_ff  <= 1'b0;
            pin_alt_oe_ff   <= 1'b0;
        end
        else
        begin
            ctrl_ff         <= nxt_ctrl;
            capture_ff      <= nxt_capture;
            flag_ff         <= nxt_flag;
            enable_ff       <= nxt_enable;
            sel_ff          <= nxt_sel;
            tmr_ctrl_ff     <= nxt_tmr_ctrl;
            timer_ff        <= nxt_timer;
            div_ff          <= nxt_div;
            ps_ff           <= nxt_ps;
            pin_ctrl_ff     <= nxt_pin_ctrl;
            wr_pend_ff      <= nxt_wr_pend;
            wr_addr_ff      <= nxt_wr_addr;
            hrdata_ff       <= nxt_hrdata;
            hreadyout_ff    <= 1'b1;
            pin_main_out_ff <= nxt_pin_main_out;
            pin_main_oe_ff  <= nxt_pin_main_oe;
            pin_alt_out_ff  <= nxt_pin_alt_out;
            pin_alt_oe_ff   <= nxt_pin_alt_oe;
        end
    end

    assign hreadyout    = hreadyout_ff;
    assign hresp        = 1'b0;
    assign hrdata       = hrdata_ff;
    assign pin_main_out = pin_main_out_ff;
    assign pin_main_oe  = pin_main_oe_ff;
    assign pin_alt_out  = pin_alt_out_ff;
    assign pin_alt_oe   = pin_alt_oe_ff;

endmodule
`default_nettype wire

// *** tcu_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module tcu_chk
    import capture_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        nrst,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        pin_main_out,
    input wire logic        pin_main_oe,
    input wire logic        pin_alt_out,
    input wire logic        pin_alt_oe
);
    logic take;
    logic rd_take;
    logic pin_take;
    assign take = hsel && hready && htrans == HTRANS_NONSEQ && hsize == HSIZE_WORD;
    assign rd_take = take && !hwrite;
    assign pin_take = take && hwrite &&
                      (haddr[7:0] == ADDR_PIN_CTRL || haddr[7:0] == ADDR_ALTPIN);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    sequence s_oe_moved;
        $changed(pin_main_oe) || $changed(pin_alt_oe);
    endsequence
    sequence s_out_moved;
        $changed(pin_main_out) || $changed(pin_alt_out);
    endsequence
    AST_OKAY: assert property (hresp == 1'b0)
        else $error("slave gave an error response");
    AST_READY: assert property (hreadyout)
        else $error("slave not ready");
    AST_RD_IDLE: assert property (!$past(rd_take) |-> hrdata == 32'h0)
        else $error("read data outside a read data phase");
    AST_RD_BYTE: assert property (hrdata[31:8] == 24'h0)
        else $error("upper read data bits not zero");
    AST_OE_CAUSE: assert property (s_oe_moved |-> $past(pin_take, 2))
        else $error("pad enable moved without a pin write");
    AST_OUT_CAUSE: assert property (s_out_moved |-> $past(pin_take, 2))
        else $error("pad drive moved without a pin write");
    AST_ONE_PAD: assert property ($onehot0({pin_main_oe, pin_alt_oe}))
        else $error("both pads driven");
    AST_RST_IN: assert property ($rose(nrst) |-> (!pin_main_oe && !pin_alt_oe)[*2])
        else $error("pad driven after reset");
endmodule
bind timer_capture_unit tcu_chk u_chk (.core_clk(core_clk), .nrst(nrst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pin_main_out(pin_main_out),
    .pin_main_oe(pin_main_oe), .pin_alt_out(pin_alt_out), .pin_alt_oe(pin_alt_oe));
`default_nettype wire

// *** pad_src.sv ***
`timescale 1ns/1ps
`default_nettype none
module pad_src
(
    input  wire logic core_clk,
    input  wire logic main_oe,
    input  wire logic main_out,
    input  wire logic alt_oe,
    input  wire logic alt_out,
    output var  logic main_lvl,
    output var  logic alt_lvl
);
    logic sig_main = 1'b0;
    logic sig_alt = 1'b0;
    assign main_lvl = main_oe ? main_out : sig_main;
    assign alt_lvl = alt_oe ? alt_out : sig_alt;
    // Each level is held three cycles so no edge is lost.
    task automatic level(input logic alt, input logic v);
        if (alt)
            sig_alt <= v;
        else
            sig_main <= v;
        repeat (3) @(posedge core_clk);
    endtask
    task automatic pulse(input logic alt);
        level(alt, 1'b1);
        level(alt, 1'b0);
    endtask
endmodule
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb
    import capture_pkg::*;
    ;
    logic        core_clk = 1'b0;
    logic        nrst = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        sleep_mode = 1'b0;
    logic        ext_timer_clk = 1'b0;
    logic        rd_ph = 1'b0;
    logic [31:0] seed = 32'h3577;
    logic [15:0] v;
    logic [7:0]  exp_q[$];
    logic [3:0]  modes[4] = '{MODE_FALL, MODE_RISE, MODE_RISE4, MODE_RISE16};
    int          edges[4] = '{1, 1, 4, 16};
    int          errors = 0;
    int          n_compared = 0;
    logic        hreadyout, hresp, pin_main_in, pin_alt_in;
    logic        pin_main_out, pin_main_oe, pin_alt_out, pin_alt_oe;
    logic [31:0] hrdata;

    always #25 core_clk = ~core_clk;

    timer_capture_unit DUT (.core_clk(core_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(HSIZE_WORD), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .sleep_mode(sleep_mode), .ext_timer_clk(ext_timer_clk), .pin_main_in(pin_main_in),
        .pin_main_out(pin_main_out), .pin_main_oe(pin_main_oe), .pin_alt_in(pin_alt_in),
        .pin_alt_out(pin_alt_out), .pin_alt_oe(pin_alt_oe));

    pad_src src (.core_clk(core_clk), .main_oe(pin_main_oe), .main_out(pin_main_out),
        .alt_oe(pin_alt_oe), .alt_out(pin_alt_out), .main_lvl(pin_main_in),
        .alt_lvl(pin_alt_in));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        xs = t ^ (t << 5);
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want)
        begin
            errors++;
            $display("BAD %0t: got %h want %h", $time, seen, want);
        end
    endtask

    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
        seed = xs(seed);
        hsel <= 1'b1;
        haddr <= {seed[31:8], a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {seed[23:0], d};
        rd_ph <= !w;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rd_ph <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(a, 1'b1, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        xfer(a, 1'b0, 8'h00);
    endtask

    // The monitor takes the oldest expectation when read data stands.
    always @(posedge core_clk)
    begin
        if (rd_ph && hreadyout === 1'b1)
            chk(hrdata, {24'h0, exp_q.pop_front()});
    end

    task automatic pulses(input int n, input logic alt);
        repeat (n) src.pulse(alt);
    endtask

    task automatic arm(input logic [3:0] m);
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_CTRL, {4'h0, m});
        wr(ADDR_FLAG, 8'h00);
    endtask

    task automatic set_tmr(input logic [15:0] t);
        wr(ADDR_TMR_LO, t[7:0]);
        wr(ADDR_TMR_HI, t[15:8]);
    endtask

    task automatic tick(input int n);
        repeat (n)
        begin
            ext_timer_clk <= 1'b1;
            repeat (2) @(posedge core_clk);
            ext_timer_clk <= 1'b0;
            repeat (2) @(posedge core_clk);
        end
    endtask

    initial
    begin
        repeat (20000) @(posedge core_clk);
        errors++;
        wrap_up();
    end

    initial
    begin
        repeat (8) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        rd(ADDR_CTRL, 8'h00);
        rd(ADDR_CAP_LO, 8'h00);
        rd(ADDR_FLAG, 8'h00);
        rd(ADDR_PIN_CTRL, 8'h01);
        rd(ADDR_ENABLE, 8'h00);
        rd(8'h28, 8'h00);
        $display("test reset done");
        wr(ADDR_TMR_CTRL, 8'h03);
        foreach (modes[i])
        begin
            arm(modes[i]);
            pulses(edges[i] - 1, 1'b0);
            rd(ADDR_FLAG, 8'h00);
            v = seed[15:0];
            set_tmr(v);
            pulses(1, 1'b0);
            rd(ADDR_CAP_LO, v[7:0]);
            rd(ADDR_CAP_HI, v[15:8]);
            rd(ADDR_FLAG, 8'h04);
        end
        $display("test modes done");
        arm(MODE_RISE);
        wr(ADDR_CAP_LO, 8'h5a);
        rd(ADDR_CAP_LO, 8'h5a);
        set_tmr(seed[15:0]);
        pulses(1, 1'b0);
        v = seed[15:0];
        set_tmr(v);
        pulses(1, 1'b0);
        rd(ADDR_CAP_LO, v[7:0]);
        rd(ADDR_CAP_HI, v[15:8]);
        arm(MODE_RISE16);
        pulses(2, 1'b0);
        wr(ADDR_CTRL, {4'h0, MODE_RISE4});
        wr(ADDR_FLAG, 8'h00);
        pulses(2, 1'b0);
        rd(ADDR_FLAG, 8'h04);
        $display("test overwrite done");
        arm(MODE_RISE);
        wr(ADDR_PIN_CTRL, 8'h00);
        wr(ADDR_PIN_CTRL, 8'h02);
        @(negedge core_clk);
        chk({31'h0, pin_main_oe & pin_main_out}, 32'h1);
        @(posedge core_clk);
        repeat (3) @(posedge core_clk);
        rd(ADDR_FLAG, 8'h04);
        wr(ADDR_ALTPIN, 8'h01);
        @(negedge core_clk);
        chk({30'h0, pin_alt_oe & pin_alt_out, pin_main_oe}, 32'h2);
        @(posedge core_clk);
        wr(ADDR_PIN_CTRL, 8'h01);
        wr(ADDR_ALTPIN, 8'h01);
        wr(ADDR_FLAG, 8'h00);
        pulses(1, 1'b0);
        rd(ADDR_FLAG, 8'h00);
        pulses(1, 1'b1);
        rd(ADDR_FLAG, 8'h04);
        wr(ADDR_ALTPIN, 8'h00);
        $display("test pins done");
        sleep_mode <= 1'b1;
        set_tmr(16'h0000);
        tick(5);
        pulses(1, 1'b0);
        rd(ADDR_CAP_LO, 8'h05);
        wr(ADDR_TMR_CTRL, 8'h01);
        wr(ADDR_TMR_LO, 8'h55);
        repeat (20) @(posedge core_clk);
        rd(ADDR_TMR_LO, 8'h55);
        sleep_mode <= 1'b0;
        $display("test sleep done");
        for (int k = 0; k < 2; k++)
        begin
            arm(MODE_RISE4);
            pulses(2, 1'b0);
            if (k == 1)
            begin
                nrst <= 1'b0;
                repeat (3) @(posedge core_clk);
                nrst <= 1'b1;
                @(posedge core_clk);
            end
            arm(MODE_RISE4);
            pulses(3, 1'b0);
            rd(ADDR_FLAG, 8'h00);
            pulses(1, 1'b0);
            rd(ADDR_FLAG, 8'h04);
        end
        $display("test prescaler done");
        @(posedge core_clk);
        wrap_up();
    end
endmodule
`default_nettype wire
